// ---- inc/iqw_defines.svh ----
// Offsets, reset values and counts shared by the waveform ingest block
`ifndef IQW_DEFINES_SVH
`define IQW_DEFINES_SVH

// Least number of I/Q pairs a finished waveform must hold
`define IQW_MIN_PAIRS      16'h003C
// Bytes that make up one I/Q point (I high, I low, Q high, Q low)
`define IQW_BYTES_PER_PT   4'h4
// Byte positions inside a point
`define IQW_POS_I_HI       2'h0
`define IQW_POS_I_LO       2'h1
`define IQW_POS_Q_HI       2'h2
`define IQW_POS_Q_LO       2'h3
// Number of header bytes kept per waveform
`define IQW_HDR_BYTES      16
// Header byte value meaning "unspecified, no setting saved"
`define IQW_HDR_UNSPEC     8'hFF
// Marker byte value for "all markers off"
`define IQW_MKR_OFF        8'h00
// Keystream seed of the extraction scrambler
`define IQW_SCR_SEED       16'hACE1
// Feedback taps of the 16-bit scrambler register
`define IQW_SCR_TAPS       16'hB400

`endif

// ---- inc/iqw_pkg.sv ----
// Types shared by the waveform ingest block
package iqw_pkg;

    // Which part of a waveform file a transfer carries
    typedef enum logic [1:0] {
        IQW_PART_IQ,
        IQW_PART_MARKER,
        IQW_PART_HEADER
    } iqw_part_t;

    // Ingest state machine
    typedef enum logic [2:0] {
        IQW_ST_IDLE,
        IQW_ST_IQ,
        IQW_ST_MARK,
        IQW_ST_HDR,
        IQW_ST_EXTRACT
    } iqw_state_t;

    // One byte of a stream, last marks the end of a part
    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } iqw_byte_t;

    // One unpacked I/Q point for the playback path
    typedef struct packed {
        logic               valid;
        logic signed [15:0] i;
        logic signed [15:0] q;
    } iqw_sample_t;

    // Status flags, held until the next I/Q download starts; done is a one-cycle pulse
    typedef struct packed {
        logic loaded;
        logic done;
        logic short_err;
        logic partial_err;
        logic name_err;
        logic order_err;
        logic overflow;
    } iqw_status_t;

endpackage

// ---- logic/iqw_scramble.sv ----
// Keystream generator that hides waveform content on extraction
`timescale 1ns/1ns
`include "iqw_defines.svh"
module iqw_scramble (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       load,
    input  wire logic       step,
    output logic [7:0]      key
);

    logic [15:0] lfsr_ff;
    logic [15:0] nxt_lfsr;

    // Galois shift, restart from the seed on every extraction
    assign nxt_lfsr = lfsr_ff[0] ? ((lfsr_ff >> 1) ^ `IQW_SCR_TAPS)
                                 : (lfsr_ff >> 1);
    assign key      = lfsr_ff[7:0];

    // --------------------
    // Keystream register
    // --------------------
    always_ff @(posedge clock) begin
        if (rst || load) begin
            lfsr_ff <= `IQW_SCR_SEED;
        end else if (step) begin
            lfsr_ff <= nxt_lfsr;
        end
    end

endmodule

// ---- logic/iqw_ingest.sv ----
// Waveform ingest: byte stream to signed I/Q pairs, marker/header upkeep
// Overview of operation
// RULE1 - Each I and each Q value is one integer made of two stream bytes.
// RULE2 - Samples are signed two's complement from -32768 up to 32767.
// RULE3 - The sender supplies at least sixty I/Q pairs per waveform.
// RULE4 - The upper byte (bits 15..8) of a sample comes first, then the lower.
// RULE5 - Four bytes are consumed per point: two for I, then two for Q.
// RULE6 - I and Q arrive interleaved in one single byte stream.
// RULE7 - Missing markers and header are created: header unspecified, markers 0.
// RULE8 - New I/Q data overwrites I/Q, markers and header; order is I/Q first.
// RULE9 - Marker, header and I/Q share one name; created parts take the I/Q name.
// RULE10 - Extraction returns content scrambled, except user-created I/Q data.
// RULE11 - Bit 15 is the sign bit, bit 0 the LSB, found in the second byte.
// RULE12 - In each pair the I sample comes first and Q follows at once.
// RULE13 - Top code is positive full scale, zero is 0 V, bottom is negative.
// RULE14 - An error is raised for too few pairs or a broken final point.
`timescale 1ns/1ns
`include "iqw_defines.svh"
module iqw_ingest #(
    parameter int MAX_POINTS = 1024,
    parameter int NAME_W     = 32,
    parameter int CNT_W      = $clog2(MAX_POINTS + 1)
) (
    input  wire logic                clock,
    input  wire logic                rst,
    input  wire iqw_pkg::iqw_byte_t  in_byte,
    input  wire logic                part_start,
    input  wire iqw_pkg::iqw_part_t  part_sel,
    input  wire logic [NAME_W-1:0]   part_name,
    input  wire logic                user_created,
    input  wire logic                extract_start,
    output logic                     in_ready,
    output iqw_pkg::iqw_sample_t     sample,
    output iqw_pkg::iqw_byte_t       ext_byte,
    output iqw_pkg::iqw_status_t     status,
    output logic [NAME_W-1:0]        wave_name,
    output logic [CNT_W-1:0]         point_count
);
    import iqw_pkg::*;

    localparam int AW    = (MAX_POINTS > 1) ? $clog2(MAX_POINTS) : 1;
    localparam int HDR_N = `IQW_HDR_BYTES;
    localparam int HW    = $clog2(HDR_N);
    localparam int XW    = CNT_W + 2;

    // --------------------
    // Storage and state
    // --------------------
    logic [31:0]       iq_mem  [MAX_POINTS];
    logic [7:0]        mkr_mem [MAX_POINTS];
    logic [7:0]        hdr_ff  [HDR_N];

    iqw_state_t        st_ff;
    iqw_state_t        nxt_st;
    logic [1:0]        phase_ff;
    logic [7:0]        hi_ff;
    logic [15:0]       i_ff;
    logic [CNT_W-1:0]  pt_ff;
    logic [CNT_W-1:0]  mk_ff;
    logic [HW-1:0]     hd_ff;
    logic              user_ff;
    logic              enc_ff;
    iqw_part_t         ext_part_ff;
    logic [XW-1:0]     ext_idx_ff;
    logic              in_ready_ff;
    iqw_sample_t       sample_ff;
    iqw_byte_t         ext_ff;
    iqw_status_t       status_ff;
    logic [NAME_W-1:0] name_ff;
    logic [CNT_W-1:0]  count_ff;

    // --------------------
    // Request decode
    // --------------------
    logic              idle;
    logic              take;
    logic              start_iq;
    logic              start_side;
    logic              name_ok;
    logic              side_ok;
    logic              start_ext;
    logic              ext_bad;

    assign idle       = (st_ff == IQW_ST_IDLE);
    assign take       = in_byte.valid && in_ready_ff;
    assign start_iq   = idle && part_start && (part_sel == IQW_PART_IQ);
    assign start_side = idle && part_start && (part_sel != IQW_PART_IQ);
    assign name_ok    = (part_name == name_ff); // RULE9
    // Markers and header only attach to an I/Q part already loaded
    assign side_ok    = start_side && status_ff.loaded && name_ok; // RULE8
    assign start_ext  = idle && !part_start && extract_start
                        && status_ff.loaded;
    assign ext_bad    = idle && !part_start && extract_start
                        && !status_ff.loaded;

    // --------------------
    // I/Q unpacking
    // --------------------
    logic              in_iq;
    logic [15:0]       word;
    logic              i_done;
    logic              pt_done;
    logic              iq_last;
    logic              room;
    logic [CNT_W-1:0]  pt_inc;
    logic [CNT_W-1:0]  pts_final;

    assign in_iq     = (st_ff == IQW_ST_IQ) && take; // RULE6
    // High byte was held, the byte now arriving carries bit 0
    assign word      = {hi_ff, in_byte.data}; // RULE4 RULE11 RULE1
    assign i_done    = in_iq && (phase_ff == `IQW_POS_I_LO); // RULE12
    assign pt_done   = in_iq && (phase_ff == `IQW_POS_Q_LO); // RULE5
    assign iq_last   = in_iq && in_byte.last;
    assign room      = (pt_ff < CNT_W'(MAX_POINTS));
    assign pt_inc    = (pt_done && room) ? CNT_W'(1) : CNT_W'(0);
    assign pts_final = pt_ff + pt_inc;

    // Point phase and holding registers
    always_ff @(posedge clock) begin
        if (rst || start_iq) begin
            phase_ff <= 2'h0;
        end else if (in_iq) begin
            phase_ff <= phase_ff + 2'h1; // RULE5
        end
    end

    // High byte and finished I value held until Q completes the pair
    always_ff @(posedge clock) begin
        if (rst) begin
            hi_ff <= 8'h00;
            i_ff  <= 16'h0000;
        end else begin
            if (in_iq && !phase_ff[0]) hi_ff <= in_byte.data; // RULE4
            if (i_done) i_ff <= word; // RULE12
        end
    end

    // Point counter, saturates at the memory size
    always_ff @(posedge clock) begin
        if (rst || start_iq) begin
            pt_ff <= '0;
        end else begin
            pt_ff <= pts_final;
        end
    end

    // --------------------
    // Marker and I/Q memory writes
    // --------------------
    logic              in_mk;
    logic              mk_we;
    logic [AW-1:0]     mk_wa;
    logic [7:0]        mk_wd;

    assign in_mk = (st_ff == IQW_ST_MARK) && take;
    // New I/Q points clear their marker byte, marker part overwrites
    assign mk_we = (pt_done && room) || (in_mk && (mk_ff < count_ff));
    assign mk_wa = pt_done ? AW'(pt_ff) : AW'(mk_ff);
    assign mk_wd = pt_done ? `IQW_MKR_OFF : in_byte.data; // RULE7 RULE8

    always_ff @(posedge clock) begin
        if (pt_done && room) iq_mem[AW'(pt_ff)] <= {i_ff, word}; // RULE8
        if (mk_we) mkr_mem[mk_wa] <= mk_wd;
    end

    // Marker byte index
    always_ff @(posedge clock) begin
        if (rst || side_ok) begin
            mk_ff <= '0;
        end else if (in_mk && mk_ff < count_ff) begin
            mk_ff <= mk_ff + CNT_W'(1);
        end
    end

    // --------------------
    // Header bytes: reset or new I/Q leaves them unspecified
    // --------------------
    logic in_hd;

    assign in_hd = (st_ff == IQW_ST_HDR) && take;

    always_ff @(posedge clock) begin
        if (rst || side_ok) begin
            hd_ff <= '0;
        end else if (in_hd) begin
            hd_ff <= hd_ff + HW'(1);
        end
    end

    for (genvar g = 0; g < HDR_N; g++) begin : g_hdr
        always_ff @(posedge clock) begin
            if (rst || start_iq) begin
                hdr_ff[g] <= `IQW_HDR_UNSPEC; // RULE7 RULE8
            end else if (in_hd && hd_ff == HW'(g)) begin
                hdr_ff[g] <= in_byte.data;
            end
        end
    end

    // --------------------
    // Extraction
    // --------------------
    logic              in_ext;
    logic [XW-1:0]     ext_len;
    logic              ext_end;
    logic [31:0]       ext_word;
    logic [7:0]        plain;
    logic [7:0]        key;

    assign in_ext   = (st_ff == IQW_ST_EXTRACT);
    assign ext_len  = (ext_part_ff == IQW_PART_IQ) ? {count_ff, 2'b00} :
                      (ext_part_ff == IQW_PART_MARKER) ? XW'(count_ff) :
                      XW'(HDR_N);
    assign ext_end  = in_ext && (ext_idx_ff + XW'(1) >= ext_len);
    assign ext_word = iq_mem[AW'(ext_idx_ff >> 2)];
    // Points leave in the order they came in: I high first
    assign plain    =
        (ext_part_ff == IQW_PART_MARKER) ? mkr_mem[AW'(ext_idx_ff)] :
        (ext_part_ff == IQW_PART_HEADER) ? hdr_ff[HW'(ext_idx_ff)] :
        ext_word[8*(3 - ext_idx_ff[1:0]) +: 8]; // RULE4

    iqw_scramble u_scramble (
        .clock (clock),
        .rst   (rst),
        .load  (start_ext),
        .step  (in_ext),
        .key   (key)
    );

    // Extraction bookkeeping
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_idx_ff  <= '0;
            ext_part_ff <= IQW_PART_IQ;
            enc_ff      <= 1'b1;
        end else if (start_ext) begin
            ext_idx_ff  <= '0;
            ext_part_ff <= part_sel;
            // Only user-made I/Q comes back in the clear
            enc_ff <= !((part_sel == IQW_PART_IQ) && user_ff); // RULE10
        end else if (in_ext) begin
            ext_idx_ff <= ext_idx_ff + XW'(1);
        end
    end

    // Outgoing byte, scrambled unless released in the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            ext_ff <= '0;
        end else begin
            ext_ff.valid <= in_ext;
            ext_ff.last  <= ext_end;
            ext_ff.data  <= in_ext ? (plain ^ (enc_ff ? key : 8'h00))
                                   : 8'h00; // RULE10
        end
    end

    // --------------------
    // State machine
    // --------------------
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            IQW_ST_IDLE: begin
                if (start_iq) begin
                    nxt_st = IQW_ST_IQ;
                end else if (side_ok) begin
                    nxt_st = (part_sel == IQW_PART_MARKER) ? IQW_ST_MARK
                                                           : IQW_ST_HDR;
                end else if (start_ext) begin
                    nxt_st = IQW_ST_EXTRACT;
                end
            end
            IQW_ST_IQ, IQW_ST_MARK, IQW_ST_HDR: begin
                if (take && in_byte.last) nxt_st = IQW_ST_IDLE;
            end
            IQW_ST_EXTRACT: begin
                if (ext_end) nxt_st = IQW_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= IQW_ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Input is stalled while content is being streamed out
    always_ff @(posedge clock) begin
        if (rst) begin
            in_ready_ff <= 1'b0;
        end else begin
            in_ready_ff <= (nxt_st != IQW_ST_EXTRACT);
        end
    end

    // --------------------
    // Sample output, straight two's complement to the DAC path
    // --------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            sample_ff <= '0;
        end else begin
            sample_ff.valid <= pt_done; // RULE12
            if (pt_done) begin
                sample_ff.i <= signed'(i_ff); // RULE2 RULE13
                sample_ff.q <= signed'(word); // RULE2 RULE13
            end
        end
    end

    // --------------------
    // Name, user flag, count and status
    // --------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            name_ff  <= '0;
            user_ff  <= 1'b0;
            count_ff <= '0;
        end else if (start_iq) begin
            // Created marker and header parts inherit this name
            name_ff  <= part_name; // RULE9
            user_ff  <= user_created;
            count_ff <= '0;
        end else if (iq_last) begin
            count_ff <= pts_final;
        end
    end

    // Flags other than done clear only at a new I/Q start, when no event can fire
    always_ff @(posedge clock) begin
        if (rst || start_iq) begin
            status_ff <= '0;
        end else begin
            status_ff.done <= iq_last;
            if (iq_last) begin
                status_ff.loaded <= 1'b1;
                // Sender owes sixty pairs; fewer is flagged here
                status_ff.short_err <=
                    (pts_final < CNT_W'(`IQW_MIN_PAIRS)); // RULE3 RULE14
                status_ff.partial_err <=
                    (phase_ff != `IQW_POS_Q_LO); // RULE14
            end
            if (start_side && !name_ok) status_ff.name_err <= 1'b1; // RULE9
            if ((start_side && !status_ff.loaded) || ext_bad) begin
                status_ff.order_err <= 1'b1; // RULE8
            end
            if (pt_done && !room) status_ff.overflow <= 1'b1;
        end
    end

    assign in_ready    = in_ready_ff;
    assign sample      = sample_ff;
    assign ext_byte    = ext_ff;
    assign status      = status_ff;
    assign wave_name   = name_ff;
    assign point_count = count_ff;

endmodule

// ---- verif/iqw_ingest_checker.sv ----
// Port-level assertions for the waveform ingest block
`timescale 1ns/1ns
module iqw_ingest_checker
    import iqw_pkg::*;
#(
    parameter int MAX_POINTS = 1024,
    parameter int NAME_W     = 32,
    parameter int CNT_W      = 11
) (
    input wire logic                clock,
    input wire logic                rst,
    input wire iqw_pkg::iqw_byte_t  in_byte,
    input wire logic                part_start,
    input wire iqw_pkg::iqw_part_t  part_sel,
    input wire logic [NAME_W-1:0]   part_name,
    input wire logic                user_created,
    input wire logic                extract_start,
    input wire logic                in_ready,
    input wire iqw_pkg::iqw_sample_t sample,
    input wire iqw_pkg::iqw_byte_t  ext_byte,
    input wire iqw_pkg::iqw_status_t status,
    input wire logic [NAME_W-1:0]   wave_name,
    input wire logic [CNT_W-1:0]    point_count
);
    logic              take;
    logic              iq_go;
    logic              iq_ff;
    logic [15:0]       bc_ff;
    logic [31:0]       sh_ff;
    logic [NAME_W-1:0] name_ff;
    logic [15:0]       ec_ff;
    iqw_part_t         es_ff;
    int                exp_len;

    // --------------------
    // Helper tracking of the open I/Q part and extraction length
    // --------------------
    assign take    = in_byte.valid && in_ready;
    assign iq_go   = part_start && part_sel == IQW_PART_IQ;
    assign exp_len = (es_ff == IQW_PART_IQ) ? 4 * int'(point_count)
                   : (es_ff == IQW_PART_MARKER) ? int'(point_count) : 16;

    // Last four taken bytes give the expected point
    always_ff @(posedge clock) begin
        iq_ff   <= !rst && (iq_go || (iq_ff && !(take && in_byte.last)));
        bc_ff   <= iq_go ? 16'h0000 : bc_ff + 16'(take && iq_ff);
        sh_ff   <= take ? {sh_ff[23:0], in_byte.data} : sh_ff;
        name_ff <= iq_go ? part_name : name_ff;
        ec_ff   <= extract_start ? 16'h0000 : ec_ff + 16'(ext_byte.valid);
        es_ff   <= extract_start ? part_sel : es_ff;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // --------------------
    // Sequences
    // --------------------
    sequence ext_go_s;
        extract_start && !part_start && status.loaded && in_ready && !iq_ff;
    endsequence
    sequence ext_lead_s;
        !in_ready ##1 ext_byte.valid;
    endsequence
    sequence iq_end_s;
        take && in_byte.last && iq_ff;
    endsequence

    samp_data_a: assert property (
        sample.valid |-> {sample.i, sample.q} == sh_ff)
        else $error("bad point");
    samp_pulse_a: assert property (
        sample.valid |=> !sample.valid)
        else $error("long point");
    done_pulse_a: assert property (
        iq_end_s |=> status.done ##1 !status.done)
        else $error("bad done");
    short_flag_a: assert property (
        iq_end_s and (int'(bc_ff) + 1 < 240) |=> status.short_err)
        else $error("short waveform not flagged");
    part_flag_a: assert property (
        iq_end_s and ((bc_ff + 16'h0001) % 4 != 0) |=> status.partial_err)
        else $error("broken final point not flagged");
    pts_count_a: assert property (
        status.done |-> int'(point_count) ==
            ((int'(bc_ff) / 4 > MAX_POINTS) ? MAX_POINTS : int'(bc_ff) / 4))
        else $error("point count wrong");
    name_keep_a: assert property (
        status.done |-> wave_name == name_ff)
        else $error("waveform name not kept");
    ext_lead_a: assert property (
        ext_go_s |=> ext_lead_s)
        else $error("late extract");
    ext_len_a: assert property (
        ext_byte.valid && ext_byte.last |-> int'(ec_ff) + 1 == exp_len)
        else $error("extraction length wrong");
    ext_block_a: assert property (
        ext_byte.valid |-> !$past(in_ready))
        else $error("input open");
    flag_hold_a: assert property (
        $fell(status.short_err) |-> $past(iq_go))
        else $error("error flag cleared early");
endmodule

// ---- verif/iqw_host.sv ----
// Host model that downloads and extracts waveform parts
`timescale 1ns/1ns
module iqw_host
    import iqw_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          in_ready,
    output iqw_pkg::iqw_byte_t in_byte,
    output iqw_pkg::iqw_part_t part_sel,
    output logic               part_start,
    output logic [31:0]        part_name,
    output logic               user_created,
    output logic               extract_start
);
    initial begin
        in_byte = '0;
        part_sel = IQW_PART_IQ;
        part_start = 1'b0;
        part_name = '0;
        user_created = 1'b0;
        extract_start = 1'b0;
    end

    // Open a part, then send its bytes on one lane with random stalls
    task automatic send_part(input iqw_part_t sel, input logic [31:0] nm,
                             input logic uc, input logic [7:0] b[$]);
        logic r;
        @(posedge clock);
        #1;
        part_start = 1'b1;
        part_sel = sel;
        part_name = nm;
        user_created = uc;
        @(posedge clock);
        #1;
        part_start = 1'b0;
        foreach (b[k]) begin
            if ($urandom_range(3) == 0) begin
                in_byte = '0;
                @(posedge clock);
                #1;
            end
            in_byte = {1'b1, k == b.size() - 1, b[k]};
            // Hold the byte until ready is seen at a falling edge and the next rising edge passes
            do begin
                @(negedge clock);
                r = in_ready;
                @(posedge clock);
            end while (r !== 1'b1);
            #1;
        end
        // Released lane shows the inverse, not a stale value
        in_byte = {2'b00, ~b[b.size() - 1]};
    endtask

    // One-cycle extraction request
    task automatic extract(input iqw_part_t sel);
        @(posedge clock);
        #1;
        extract_start = 1'b1;
        part_sel = sel;
        @(posedge clock);
        #1;
        extract_start = 1'b0;
    endtask
endmodule

// ---- verif/iqw_ingest_bench.sv ----
// Self-checking bench for the waveform ingest block
`timescale 1ns/1ns
`include "iqw_defines.svh"
module iqw_ingest_bench;
    import iqw_pkg::*;
    localparam int MAXP = 64;
    localparam logic [31:0] NM = 32'h5A5A0001;
    localparam logic [15:0] COR [6] = '{16'h7FFF, 16'h8000, 16'h0000,
                                        16'hFFFF, 16'h0001, 16'h1234};
    logic        clock;
    logic        rst;
    iqw_byte_t   in_byte;
    iqw_byte_t   ext_byte;
    iqw_part_t   part_sel;
    logic        part_start;
    logic [31:0] part_name;
    logic        user_created;
    logic        extract_start;
    logic        in_ready;
    iqw_sample_t sample;
    iqw_status_t status;
    logic [31:0] wave_name;
    logic [6:0]  point_count;
    int          error_cnt;
    int          checks_done;
    int          cycles, dn;
    logic [7:0]  st[$], ex[$], got[$];
    logic [31:0] smp[$];

    iqw_ingest #(.MAX_POINTS(MAXP), .NAME_W(32)) DUT (
        .clock(clock), .rst(rst), .in_byte(in_byte),
        .part_start(part_start), .part_sel(part_sel),
        .part_name(part_name), .user_created(user_created),
        .extract_start(extract_start), .in_ready(in_ready),
        .sample(sample), .ext_byte(ext_byte), .status(status),
        .wave_name(wave_name), .point_count(point_count));
    iqw_host HOST (
        .clock(clock), .in_ready(in_ready), .in_byte(in_byte),
        .part_sel(part_sel), .part_start(part_start),
        .part_name(part_name), .user_created(user_created),
        .extract_start(extract_start));

    always #10 clock = ~clock;

    // Monitor collects points and extracted bytes; also cuts a hang
    always @(negedge clock) begin
        cycles++;
        if (sample.valid === 1'b1) smp.push_back({sample.i, sample.q});
        if (ext_byte.valid === 1'b1) got.push_back(ext_byte.data);
        if (status.done === 1'b1) dn++;
        if (cycles == 40000) begin
            error_cnt++;
            final_report();
        end
    end

    // --------------------
    // Expectation helpers
    // --------------------
    function automatic logic [7:0] key_at(input int n);
        logic [15:0] s;
        s = `IQW_SCR_SEED;
        repeat (n) s = s[0] ? (s >> 1) ^ `IQW_SCR_TAPS : s >> 1;
        return s[7:0];
    endfunction

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    // Fill ex with n bytes, random or constant
    task automatic fillx(input int n, input logic [7:0] v, input logic r);
        ex.delete();
        repeat (n) ex.push_back(r ? 8'($urandom) : v);
    endtask

    // Download n points plus x stray bytes and check the unpacking
    task automatic iq_load(input logic [31:0] nm, input logic uc,
                           input int np, input int x);
        logic [15:0] v;
        int d0;
        st.delete();
        smp.delete();
        d0 = dn;
        for (int k = 0; k < 2 * np; k++) begin
            v = (k < 6) ? COR[k] : 16'($urandom);
            st.push_back(v[15:8]);
            st.push_back(v[7:0]);
        end
        repeat (x) st.push_back(8'($urandom));
        HOST.send_part(IQW_PART_IQ, nm, uc, st);
        repeat (2) @(posedge clock);
        #1;
        check("point total", np, smp.size());
        foreach (smp[p]) check("point", {st[4*p], st[4*p+1], st[4*p+2],
            st[4*p+3]}, smp[p]);
        check("done pulses", d0 + 1, dn);
        check("short flag", np < 60, status.short_err);
        check("partial flag", x != 0, status.partial_err);
        check("point count", np, point_count);
        check("name", nm, wave_name);
        check("loaded", 1, status.loaded);
        check("overflow", 0, status.overflow);
        st = st[0:4*np-1];
    endtask

    // Extract one part and compare with the expected plain bytes
    task automatic xcheck(input iqw_part_t sel, input logic [7:0] e[$],
                          input logic scr);
        int n;
        got.delete();
        HOST.extract(sel);
        n = 0;
        while (got.size() < e.size() && n < 2000) begin
            @(posedge clock);
            n++;
        end
        repeat (3) @(posedge clock);
        check("ext count", e.size(), got.size());
        foreach (e[k]) if (k < got.size())
            check("ext byte", e[k] ^ (scr ? key_at(k) : 8'h00), got[k]);
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        error_cnt = 0;
        checks_done = 0;
        cycles = 0;
        dn = 0;
        void'($urandom(4));
        repeat (16) @(posedge clock);
        #1;
        rst = 1'b0;
        fillx(1, 8'h01, 1'b0);
        HOST.send_part(IQW_PART_MARKER, NM, 1'b0, ex);
        repeat (2) @(posedge clock);
        check("order flag", 1, status.order_err);
        iq_load(NM, 1'b1, MAXP, 0);
        fillx(16, `IQW_HDR_UNSPEC, 1'b0);
        xcheck(IQW_PART_HEADER, ex, 1'b1);
        fillx(MAXP, `IQW_MKR_OFF, 1'b0);
        xcheck(IQW_PART_MARKER, ex, 1'b1);
        xcheck(IQW_PART_IQ, st, 1'b0);
        HOST.send_part(IQW_PART_MARKER, NM ^ 32'h1, 1'b0, ex);
        repeat (2) @(posedge clock);
        check("name flag", 1, status.name_err);
        fillx(MAXP, 8'h00, 1'b1);
        HOST.send_part(IQW_PART_MARKER, NM, 1'b0, ex);
        xcheck(IQW_PART_MARKER, ex, 1'b1);
        fillx(16, 8'h00, 1'b1);
        HOST.send_part(IQW_PART_HEADER, NM, 1'b0, ex);
        xcheck(IQW_PART_HEADER, ex, 1'b1);
        iq_load(NM + 32'h1, 1'b0, 59, 2);
        fillx(16, `IQW_HDR_UNSPEC, 1'b0);
        xcheck(IQW_PART_HEADER, ex, 1'b1);
        fillx(59, `IQW_MKR_OFF, 1'b0);
        xcheck(IQW_PART_MARKER, ex, 1'b1);
        xcheck(IQW_PART_IQ, st, 1'b1);
        final_report();
    end
endmodule

bind iqw_ingest iqw_ingest_checker #(
    .MAX_POINTS(MAX_POINTS), .NAME_W(NAME_W), .CNT_W(CNT_W)) chk (
    .clock(clock), .rst(rst), .in_byte(in_byte),
    .part_start(part_start), .part_sel(part_sel),
    .part_name(part_name), .user_created(user_created),
    .extract_start(extract_start), .in_ready(in_ready),
    .sample(sample), .ext_byte(ext_byte), .status(status),
    .wave_name(wave_name), .point_count(point_count));
